// File: core/timer8_wave.sv
/*
  8-bit timer/counter with waveform generation and compare-output control,
  reached over AHB-Lite. Holds the counter, compare buffers, flags and the
  pin override for two waveform outputs.
  Assumes the timer tick is a one-cycle enable from an outside prescaler
  and that the port direction bits come from the port block.
*/
// Added by the designer: the AHB-Lite register port.
// Overview of operation
// [R1] Counter runs on the core clock; the timer tick is only an enable.
// [R2] Clear-on-match and compare-A-top fast PWM: match A flags and clears.
// [R3] Nonzero channel A action overrides the pin; driven if direction out.
// [R4] Non-PWM channel A: off, toggle, clear or set on match.
// [R5] PWM channel A action 01: off if upper mode bit 0, else toggle.
// [R6] Fast PWM A: 10 clear on match set at BOTTOM; 11 the inverse.
// [R7] Fast PWM with compare at TOP: match ignored, BOTTOM action only.
// [R8] Phase-correct A: 10 clears on up match, sets on down; 11 inverse.
// [R9] Phase-correct with compare at TOP: match ignored, action at TOP.
// [R10] Nonzero channel B action overrides the pin; driven if direction out.
// [R11] Non-PWM channel B: off, toggle, clear or set on match.
// [R12] Fast PWM B: 01 reserved; 10 clear/BOTTOM set; 11 inverse.
// [R13] Phase-correct B: 01 reserved; 10 up-clear down-set; 11 inverse.
// [R14] Control A bits 3 and 2 ignore writes and read zero.
// [R15] Mode value picks normal, clear-on-match, fast or phase PWM and TOP.
// [R16] Compare writes apply at once, at TOP, or at BOTTOM by mode.
// [R17] Overflow flag at MAX in 0,2,3; BOTTOM in 1,5; TOP in 7.
// [R18] Upper mode bit is control B bit 3, joined with control A bits.
// [R19] Fast PWM counts up to TOP and clears on the next tick.
// [R20] Phase-correct turns at TOP and holds TOP for one tick.
// [R21] Waveform registers reset low; mode and action fields reset to zero.
`default_nettype none
module timer8_wave #(
  parameter int unsigned ADDR_WIDTH = 12  // Bus address width
) (
  input  wire logic                  CORE_CLK,       // 250 MHz clock
  input  wire logic                  SRST,           // Sync reset, high
  input  wire logic                  CLK_EN,         // Freezes all state
  input  wire logic                  TIMER_TICK,     // Count enable pulse
  input  wire logic                  DIR_A,          // Pin A direction out
  input  wire logic                  DIR_B,          // Pin B direction out
  input  wire logic                  HSEL,           // Slave select
  input  wire logic [ADDR_WIDTH-1:0] HADDR,          // Byte address
  input  wire logic [1:0]            HTRANS,         // Transfer type
  input  wire logic                  HWRITE,         // Write when high
  input  wire logic [2:0]            HSIZE,          // Transfer size
  input  wire logic [31:0]           HWDATA,         // Write data
  input  wire logic                  HREADY,         // Bus ready in
  output logic      [31:0]           HRDATA,         // Read data
  output logic                       HREADYOUT,      // Slave ready
  output logic                       HRESP,          // Always OKAY
  output logic                       WAVE_OUT_A,     // Pin A level
  output logic                       WAVE_OE_A,      // Pin A drive enable
  output logic                       WAVE_OUT_B,     // Pin B level
  output logic                       WAVE_OE_B,      // Pin B drive enable
  output logic                       PORT_OVR_A,     // Pin A overridden
  output logic                       PORT_OVR_B,     // Pin B overridden
  output logic                       MATCH_A_FLAG,   // Sticky match A
  output logic                       MATCH_B_FLAG,   // Sticky match B
  output logic                       OVERFLOW_FLAG   // Sticky overflow
);
  import timer8_pkg::*;

  localparam int unsigned IDX_W = 8;

  if (ADDR_WIDTH < IDX_W + ADDR_SHIFT) begin : g_bad_addr
    $error("ADDR_WIDTH too small for the register map");
  end

  logic [7:0] timer_control_a_r;
  logic       wave_mode_high_r;
  logic [7:0] count_value_r;
  logic [7:0] cmp_buf_r [2];
  logic [7:0] cmp_act_r [2];
  logic [2:0] flags_r;
  logic       block_match_r;
  dir_e       dir_r;
  logic       wr_pend_r;
  logic [7:0] wr_idx_r;
  logic [1:0] wave;
  logic [1:0] act [2];
  logic [1:0] match;
  logic [1:0] cmp_is_top;
  logic [1:0] connected;
  logic [2:0] flags_set;
  logic [2:0] mode_raw;
  mode_e      mode;
  logic [7:0] top_val;
  logic [7:0] count_nxt;
  dir_e       dir_nxt;
  logic       tick;
  logic       fast_pwm;
  logic       pc_pwm;
  logic       at_top;
  logic       bottom_evt;
  logic       top_evt;
  logic       load_cmp;
  logic       addr_ok;
  logic [7:0] addr_idx;
  logic [7:0] rd_val;
  logic [7:0] wdat;

  assign tick     = CLK_EN && TIMER_TICK; // [R1]
  assign mode_raw = {wave_mode_high_r,
                     timer_control_a_r[MODE_LOW_LSB +: 2]}; // [R18]
  assign act[0]   = timer_control_a_r[ACT_A_LSB +: 2];
  assign act[1]   = timer_control_a_r[ACT_B_LSB +: 2];

  always_comb begin
    unique case (mode_raw) // [R15]
      MODE_NORMAL:  mode = MD_NORMAL;
      MODE_PC_FF:   mode = MD_PC_FF;
      MODE_CTC:     mode = MD_CTC;
      MODE_FAST_FF: mode = MD_FAST_FF;
      MODE_RSV4:    mode = MD_RSVD;
      MODE_PC_CA:   mode = MD_PC_CA;
      MODE_RSV6:    mode = MD_RSVD;
      MODE_FAST_CA: mode = MD_FAST_CA;
    endcase
  end

  assign fast_pwm = (mode == MD_FAST_FF) || (mode == MD_FAST_CA);
  assign pc_pwm   = (mode == MD_PC_FF) || (mode == MD_PC_CA);
  assign top_val  = (mode == MD_CTC || mode == MD_PC_CA
                     || mode == MD_FAST_CA) ? cmp_act_r[0] : MAX_VAL;
  assign at_top     = count_value_r == top_val;
  assign bottom_evt = tick && fast_pwm && at_top; // [R19]
  assign top_evt    = tick && pc_pwm && at_top && dir_r == DIR_UP;

  // Count sequence per mode; reserved modes hold the count
  always_comb begin
    count_nxt = count_value_r;
    dir_nxt   = dir_r;
    unique case (mode)
      MD_NORMAL: count_nxt = count_value_r + ONE_VAL;
      MD_CTC, MD_FAST_FF, MD_FAST_CA: begin
        count_nxt = at_top ? BOTTOM_VAL
                           : count_value_r + ONE_VAL; // [R2] [R19]
      end
      MD_PC_FF, MD_PC_CA: begin
        if (dir_r == DIR_UP) begin
          if (at_top) begin
            dir_nxt   = DIR_DOWN; // [R20]
            count_nxt = (count_value_r == BOTTOM_VAL) ? BOTTOM_VAL
                                                      : count_value_r - ONE_VAL;
          end else begin
            count_nxt = count_value_r + ONE_VAL;
          end
        end else if (count_value_r == BOTTOM_VAL) begin
          dir_nxt   = DIR_UP;
          count_nxt = (top_val == BOTTOM_VAL) ? BOTTOM_VAL : ONE_VAL;
        end else begin
          count_nxt = count_value_r - ONE_VAL;
        end
      end
      MD_RSVD: count_nxt = count_value_r;
    endcase
  end

  // Compare buffers load at once, at TOP or at BOTTOM by mode
  always_comb begin
    unique case (mode) // [R16]
      MD_PC_FF, MD_PC_CA:     load_cmp = top_evt;
      MD_FAST_FF, MD_FAST_CA: load_cmp = bottom_evt;
      default:                load_cmp = 1'b1;
    endcase
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      assign match[g] = tick && !block_match_r
                        && count_value_r == cmp_act_r[g];
      assign cmp_is_top[g] = cmp_act_r[g] == top_val;
      // PWM action 01 stays disconnected on B and on A with mode bit low
      assign connected[g] = (act[g] != ACT_OFF)
                            && !((fast_pwm || pc_pwm) && act[g] == ACT_TOG
                                 && !(g == 0 && wave_mode_high_r));

      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          cmp_act_r[g] <= RST_REG;
        end else if (CLK_EN && load_cmp) begin
          cmp_act_r[g] <= cmp_buf_r[g];
        end
      end

      wave_chan #(
        .TOGGLE_IN_PWM (g == 0)
      ) u_wave (
        .clk        (CORE_CLK),
        .rst        (SRST),
        .ce         (CLK_EN),
        .action     (act[g]),
        .mode_high  (wave_mode_high_r),
        .fast_pwm   (fast_pwm),
        .pc_pwm     (pc_pwm),
        .match      (match[g]),
        .cmp_is_top (cmp_is_top[g]),
        .bottom_evt (bottom_evt),
        .top_evt    (top_evt),
        .up         (dir_r == DIR_UP),
        .wave       (wave[g])
      );
    end
  endgenerate

  always_comb begin
    flags_set          = '0;
    flags_set[FLAG_MA] = match[0];
    flags_set[FLAG_MB] = match[1];
    unique case (mode) // [R17]
      MD_NORMAL, MD_CTC, MD_FAST_FF:
        flags_set[FLAG_OVF] = tick && count_value_r == MAX_VAL;
      MD_PC_FF, MD_PC_CA:
        flags_set[FLAG_OVF] = tick && dir_r == DIR_DOWN
                              && count_value_r == BOTTOM_VAL;
      MD_FAST_CA:
        flags_set[FLAG_OVF] = tick && at_top;
      MD_RSVD:
        flags_set[FLAG_OVF] = 1'b0;
    endcase
  end

  // Bus: address phase is registered, write lands in the data phase
  assign addr_idx = HADDR[ADDR_SHIFT +: IDX_W];
  assign addr_ok  = HSEL && HTRANS[1] && HREADY;
  assign wdat     = HWDATA[7:0];

  always_comb begin
    unique case (addr_idx)
      IDX_CTRL_A: rd_val = timer_control_a_r & CTRL_A_WMASK; // [R14]
      IDX_CTRL_B: rd_val = 8'(wave_mode_high_r) << MODE_HIGH_BIT;
      IDX_COUNT:  rd_val = count_value_r;
      IDX_CMP_A:  rd_val = cmp_buf_r[0];
      IDX_CMP_B:  rd_val = cmp_buf_r[1];
      IDX_FLAGS:  rd_val = {5'h00, flags_r};
      default:    rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else if (CLK_EN) begin
      wr_pend_r <= addr_ok && HWRITE;
      wr_idx_r  <= addr_idx;
      HRDATA    <= (addr_ok && !HWRITE) ? {24'h00_0000, rd_val}
                                        : 32'h0000_0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      timer_control_a_r <= RST_REG; // [R21]
      wave_mode_high_r  <= 1'b0;
      cmp_buf_r[0]      <= RST_REG;
      cmp_buf_r[1]      <= RST_REG;
    end else if (CLK_EN && wr_pend_r) begin
      if (wr_idx_r == IDX_CTRL_A) begin
        timer_control_a_r <= wdat & CTRL_A_WMASK; // [R14]
      end
      if (wr_idx_r == IDX_CTRL_B) begin
        wave_mode_high_r <= wdat[MODE_HIGH_BIT]; // [R18]
      end
      if (wr_idx_r == IDX_CMP_A) begin
        cmp_buf_r[0] <= wdat;
      end
      if (wr_idx_r == IDX_CMP_B) begin
        cmp_buf_r[1] <= wdat;
      end
    end
  end

  // A count write wins over the tick and masks the next tick's match
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      count_value_r <= BOTTOM_VAL;
      dir_r         <= DIR_UP;
      block_match_r <= 1'b0;
    end else if (CLK_EN) begin
      if (wr_pend_r && wr_idx_r == IDX_COUNT) begin
        count_value_r <= wdat;
        block_match_r <= 1'b1;
      end else if (tick) begin
        count_value_r <= count_nxt; // [R1]
        dir_r         <= dir_nxt;
        block_match_r <= 1'b0;
      end
    end
  end

  // Write-one-to-clear; a same-cycle hardware set wins
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      flags_r <= 3'h0;
    end else if (CLK_EN) begin
      flags_r <= (flags_r & ~((wr_pend_r && wr_idx_r == IDX_FLAGS)
                              ? wdat[2:0] : 3'h0)) | flags_set;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      WAVE_OUT_A    <= 1'b0;
      WAVE_OUT_B    <= 1'b0;
      WAVE_OE_A     <= 1'b0;
      WAVE_OE_B     <= 1'b0;
      PORT_OVR_A    <= 1'b0;
      PORT_OVR_B    <= 1'b0;
      MATCH_A_FLAG  <= 1'b0;
      MATCH_B_FLAG  <= 1'b0;
      OVERFLOW_FLAG <= 1'b0;
    end else if (CLK_EN) begin
      WAVE_OUT_A    <= wave[0];
      WAVE_OUT_B    <= wave[1];
      WAVE_OE_A     <= connected[0] && DIR_A; // [R3]
      WAVE_OE_B     <= connected[1] && DIR_B; // [R10]
      PORT_OVR_A    <= connected[0];
      PORT_OVR_B    <= connected[1];
      MATCH_A_FLAG  <= flags_r[FLAG_MA];
      MATCH_B_FLAG  <= flags_r[FLAG_MB];
      OVERFLOW_FLAG <= flags_r[FLAG_OVF];
    end
  end

  ctc_clear_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R2]
    (mode == MD_CTC && match[0] && !wr_pend_r) |=>
      count_value_r == BOTTOM_VAL && flags_r[FLAG_MA])
    else $error("match A did not clear counter");
  oe_gate_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R3]
    CLK_EN |=> WAVE_OE_A == ($past(connected[0]) && $past(DIR_A)))
    else $error("pin A enable wrong");
  rsvd_bits_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R14]
    (addr_ok && !HWRITE && addr_idx == IDX_CTRL_A && CLK_EN) |=>
      HRDATA[3:2] == 2'b00)
    else $error("reserved control bits read back set");
  fast_wrap_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R19]
    (fast_pwm && tick && at_top && !wr_pend_r) |=>
      count_value_r == BOTTOM_VAL)
    else $error("fast PWM did not wrap at top");
  pc_turn_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R20]
    (pc_pwm && tick && at_top && dir_r == DIR_UP && !wr_pend_r) |=>
      dir_r == DIR_DOWN)
    else $error("phase PWM did not turn at top");
  ovf_max_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R17]
    (mode == MD_NORMAL && tick && count_value_r == MAX_VAL) |=>
      flags_r[FLAG_OVF])
    else $error("overflow not flagged at max");
  cmp_load_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R16]
    (fast_pwm && CLK_EN && !bottom_evt) |=>
      $stable(cmp_act_r[0]))
    else $error("fast PWM compare loaded off bottom");
  np_set_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R4]
    (!fast_pwm && !pc_pwm && act[0][1] && match[0]) |=>
      wave[0] == $past(act[0][0]))
    else $error("set or clear on match failed");
  pwm_b01_a: assert property (@(posedge CORE_CLK) disable iff (SRST) // [R12]
    (fast_pwm && act[1] == ACT_TOG && CLK_EN) |=> $stable(wave[1]))
    else $error("reserved B action changed output");
endmodule : timer8_wave
`default_nettype wire

// File: inc/timer8_pkg.sv
/*
  Shared constants for the 8-bit timer waveform block: register indices,
  field positions, reset values and counting-mode codes.
  Assumes a 32-bit AHB-Lite register bus, one register per aligned word.
*/
`default_nettype none
package timer8_pkg;
  // Register indices; the byte address is the index shifted by ADDR_SHIFT
  localparam logic [7:0] IDX_CTRL_A = 8'h24;
  localparam logic [7:0] IDX_CTRL_B = 8'h25;
  localparam logic [7:0] IDX_COUNT  = 8'h26;
  localparam logic [7:0] IDX_CMP_A  = 8'h27;
  localparam logic [7:0] IDX_CMP_B  = 8'h28;
  localparam logic [7:0] IDX_FLAGS  = 8'h29;
  localparam int unsigned ADDR_SHIFT = 2;

  // Control A fields
  localparam int unsigned ACT_A_LSB     = 6;
  localparam int unsigned ACT_B_LSB     = 4;
  localparam int unsigned MODE_LOW_LSB  = 0;
  localparam logic [7:0]  CTRL_A_WMASK  = 8'hF3;
  // Control B field
  localparam int unsigned MODE_HIGH_BIT = 3;
  // Flag register bits
  localparam int unsigned FLAG_OVF = 0;
  localparam int unsigned FLAG_MA  = 1;
  localparam int unsigned FLAG_MB  = 2;

  localparam logic [7:0] RST_REG    = 8'h00;
  localparam logic [7:0] MAX_VAL    = 8'hFF;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  localparam logic [7:0] ONE_VAL    = 8'h01;

  // Compare-action codes
  localparam logic [1:0] ACT_OFF = 2'h0;
  localparam logic [1:0] ACT_TOG = 2'h1;
  localparam logic [1:0] ACT_CLR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Raw three-bit mode values
  localparam logic [2:0] MODE_NORMAL  = 3'h0;
  localparam logic [2:0] MODE_PC_FF   = 3'h1;
  localparam logic [2:0] MODE_CTC     = 3'h2;
  localparam logic [2:0] MODE_FAST_FF = 3'h3;
  localparam logic [2:0] MODE_RSV4    = 3'h4;
  localparam logic [2:0] MODE_PC_CA   = 3'h5;
  localparam logic [2:0] MODE_RSV6    = 3'h6;
  localparam logic [2:0] MODE_FAST_CA = 3'h7;

  typedef enum logic [6:0] {
    MD_NORMAL  = 7'b0000001,
    MD_PC_FF   = 7'b0000010,
    MD_CTC     = 7'b0000100,
    MD_FAST_FF = 7'b0001000,
    MD_RSVD    = 7'b0010000,
    MD_PC_CA   = 7'b0100000,
    MD_FAST_CA = 7'b1000000
  } mode_e;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_e;
endpackage : timer8_pkg
`default_nettype wire

// File: core/wave_chan.sv
/*
  One compare-output waveform register for the 8-bit timer.
  Assumes the parent supplies tick-qualified match, bottom and top events.
*/
`default_nettype none
module wave_chan #(
  parameter bit TOGGLE_IN_PWM = 1'b1  // Channel allows toggle in PWM
) (
  input  wire logic       clk,        // Core clock
  input  wire logic       rst,        // Synchronous reset
  input  wire logic       ce,         // Clock enable
  input  wire logic [1:0] action,     // Compare action field
  input  wire logic       mode_high,  // Upper mode bit
  input  wire logic       fast_pwm,   // Fast PWM mode
  input  wire logic       pc_pwm,     // Phase-correct PWM mode
  input  wire logic       match,      // Qualified compare match
  input  wire logic       cmp_is_top, // Compare value equals TOP
  input  wire logic       bottom_evt, // Fast PWM wrap to BOTTOM
  input  wire logic       top_evt,    // Phase-correct turn at TOP
  input  wire logic       up,         // Counting upward
  output var  logic       wave        // Waveform register
);
  import timer8_pkg::*;

  logic wave_nxt;

  always_comb begin
    wave_nxt = wave;
    if (fast_pwm || pc_pwm) begin
      if (action == ACT_TOG) begin
        if (TOGGLE_IN_PWM && mode_high && match) begin
          wave_nxt = ~wave; // [R5]
        end
      end else if (action[1]) begin
        if (fast_pwm) begin
          if (match && !cmp_is_top) begin
            wave_nxt = action[0]; // [R6] [R12]
          end
          if (bottom_evt) begin
            wave_nxt = ~action[0]; // [R6] [R7] [R12]
          end
        end else if (cmp_is_top) begin
          if (top_evt) begin
            wave_nxt = ~action[0]; // [R9]
          end
        end else if (match) begin
          wave_nxt = up ? action[0] : ~action[0]; // [R8] [R13]
        end
      end
    end else if (match) begin
      unique case (action)
        ACT_OFF: wave_nxt = wave; // [R4] [R11]
        ACT_TOG: wave_nxt = ~wave;
        ACT_CLR: wave_nxt = 1'b0;
        ACT_SET: wave_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wave <= 1'b0; // [R21]
    end else if (ce) begin
      wave <= wave_nxt;
    end
  end
endmodule : wave_chan
`default_nettype wire

// File: verif/pin_load.sv
/*
  Port pin with a pull-down load, fed by the timer's waveform outputs.
  Assumes level and enable come straight from the timer's pin ports.
*/
`default_nettype none
module pin_load (
  input  wire logic wave, // Waveform level
  input  wire logic oe,   // Drive enable
  output var  logic pin   // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pin falls to the pull-down, never keeps the last level
  always_comb pin = oe ? wave : 1'b0;
endmodule : pin_load
`default_nettype wire

// File: verif/timer8_waveform_output_control_tb.sv
/*
  Self-checking bench for the 8-bit timer waveform block: duty table over
  PWM, CTC and normal modes, then register, reset, pin and flag cases.
  Assumes the timer package and a pull-down pin load model.
*/
`default_nettype none
module timer8_waveform_output_control_tb
  import timer8_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [7:0] ca, cb, pa, pb;
    int         dv, win;
    logic [31:0] ea, eb;
  } row_s;
  logic        clk = 0, srst = 1, tick = 0, dir_a = 1, dir_b = 1;
  logic        hsel = 0, hwrite = 0, ce = 1;
  logic [11:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic [31:0] hwdata = '0, hrdata, rdv;
  logic        hreadyout, hresp, wout_a, oe_a, wout_b, oe_b;
  logic        ovr_a, ovr_b, mfa, mfb, ovf, pin_a, pin_b;
  logic [31:0] ha, hb;
  int          fails = 0, cmp_count = 0, div = 1, tcnt = 0;
  row_s rows[9] = '{
    '{8'hB3, 8'h00, 8'h40, 8'h80, 1, 256, 65, 127},
    '{8'hE3, 8'h00, 8'h00, 8'hFF, 1, 256, 255, 256},
    '{8'hB1, 8'h00, 8'h40, 8'h40, 1, 510, 128, 382},
    '{8'hE1, 8'h00, 8'h80, 8'hFF, 1, 510, 254, 510},
    '{8'h53, 8'h08, 8'h0F, 8'h00, 1, 32, 16, 0},
    '{8'h53, 8'h08, 8'h0F, 8'h00, 2, 64, 32, 0},
    '{8'h21, 8'h08, 8'h0F, 8'h08, 1, 30, 0, 16},
    '{8'h72, 8'h00, 8'h07, 8'h03, 1, 16, 8, 16},
    '{8'h90, 8'h00, 8'h10, 8'h10, 1, 512, 0, 256}
  };

  initial begin
    forever #2 clk = ~clk;
  end
  // Tick is a one-cycle enable every div cycles
  always @(posedge clk) begin
    tcnt <= (tcnt + 1 >= div) ? 0 : tcnt + 1;
    tick <= (tcnt == 0);
  end

  timer8_wave i_dut (
    .CORE_CLK(clk), .SRST(srst), .CLK_EN(ce), .TIMER_TICK(tick),
    .DIR_A(dir_a), .DIR_B(dir_b), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .WAVE_OUT_A(wout_a), .WAVE_OE_A(oe_a),
    .WAVE_OUT_B(wout_b), .WAVE_OE_B(oe_b), .PORT_OVR_A(ovr_a),
    .PORT_OVR_B(ovr_b), .MATCH_A_FLAG(mfa), .MATCH_B_FLAG(mfb),
    .OVERFLOW_FLAG(ovf));
  pin_load i_pin_a (.wave(wout_a), .oe(oe_a), .pin(pin_a));
  pin_load i_pin_b (.wave(wout_b), .oe(oe_b), .pin(pin_b));

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // Ready is read at the edge itself; the slave moves it only by NBA
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      finish_test();
    end
  endtask : wait_rdy

  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {2'b00, idx, 2'b00};
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rdv = hrdata;
  endtask : bus

  task automatic duty(input int n);
    ha = '0;
    hb = '0;
    repeat (n) begin
      @(negedge clk);
      ha = ha + pin_a;
      hb = hb + pin_b;
    end
  endtask : duty

  task automatic rst_pulse();
    @(posedge clk);
    srst <= 1'b1;
    cyc(12);
    srst <= 1'b0;
  endtask : rst_pulse

  initial begin
    cyc(12);
    srst <= 1'b0;
    foreach (rows[i]) begin
      div <= rows[i].dv;
      bus(IDX_CTRL_B, 1'b1, rows[i].cb);
      bus(IDX_CTRL_A, 1'b1, rows[i].ca);
      bus(IDX_CMP_A, 1'b1, rows[i].pa);
      bus(IDX_CMP_B, 1'b1, rows[i].pb);
      bus(IDX_COUNT, 1'b1, 8'h00);
      cyc(1100);
      duty(rows[i].win);
      chk(ha, rows[i].ea);
      chk(hb, rows[i].eb);
      $display("duty row %0d done", i);
    end
    div <= 1;
    rst_pulse();
    @(negedge clk);
    chk({hreadyout, hresp, wout_a, ovr_a, oe_b, ovf}, 32'h20);
    bus(IDX_CTRL_A, 1'b0, 8'h00);
    chk(rdv, 32'h0);
    bus(IDX_CTRL_B, 1'b0, 8'h00);
    chk(rdv, 32'h0);
    bus(IDX_CTRL_A, 1'b1, 8'hFF);
    bus(IDX_CTRL_A, 1'b0, 8'h00);
    chk(rdv, 32'hF3);
    bus(IDX_CTRL_B, 1'b1, 8'hFF);
    bus(IDX_CTRL_B, 1'b0, 8'h00);
    chk(rdv, 32'h08);
    bus(8'h3F, 1'b0, 8'h00);
    chk(rdv, 32'h0);
    $display("reset and registers done");
    // Pin stays owned by the waveform but undriven when direction is in
    dir_a <= 1'b0;
    cyc(3);
    @(negedge clk);
    chk({ovr_a, oe_a, pin_a}, 32'h4);
    @(posedge clk);
    dir_a <= 1'b1;
    $display("pin direction done");
    bus(IDX_CTRL_B, 1'b1, 8'h00);
    bus(IDX_CTRL_A, 1'b1, 8'h03);
    bus(IDX_COUNT, 1'b1, 8'hE0);
    bus(IDX_FLAGS, 1'b1, 8'h07);
    bus(IDX_FLAGS, 1'b0, 8'h00);
    chk(rdv & 32'h1, 32'h0);
    // A frozen clock enable must hold the count short of MAX
    ce <= 1'b0;
    cyc(60);
    @(negedge clk);
    chk(ovf, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    cyc(40);
    @(negedge clk);
    chk(ovf, 1'b1);
    $display("overflow and freeze done");
    bus(IDX_CMP_A, 1'b1, 8'h05);
    bus(IDX_CTRL_A, 1'b1, 8'h02);
    // Count may sit above the new TOP, so let it wrap once first
    cyc(300);
    bus(IDX_FLAGS, 1'b1, 8'h07);
    repeat (4) begin
      bus(IDX_COUNT, 1'b0, 8'h00);
      chk(rdv <= 32'h5, 1'b1);
    end
    @(negedge clk);
    chk(mfa, 1'b1);
    $display("clear on match done");
    finish_test();
  end
endmodule : timer8_waveform_output_control_tb
`default_nettype wire
